// File: sfe_pkg.sv
package sfe_pkg;
    // ********************************
    // opcodes
    // ********************************
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_CHIP_ERASE = 8'hC7;
    localparam logic [7:0] OP_CHIP_ERASE_ALT = 8'h60;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_QUAD_PAGE_PROGRAM = 8'h38;
    localparam logic [7:0] OP_DEEP_SLEEP = 8'hB9;
    localparam logic [7:0] OP_WAKE_FROM_SLEEP = 8'hAB;
    localparam logic [7:0] OP_ENTER_OTP = 8'hB1;
    localparam logic [7:0] OP_EXIT_OTP = 8'hC1;
    localparam logic [7:0] OP_READ_SECURITY_REG = 8'h2B;
    localparam logic [7:0] OP_WRITE_SECURITY_REG = 8'h2F;

    // ********************************
    // security register fields
    // ********************************
    localparam int SEC_PROT_SEL = 7;
    localparam int SEC_ERASE_FAIL = 6;
    localparam int SEC_PROG_FAIL = 5;
    localparam int SEC_ERASE_SUSP = 3;
    localparam int SEC_PROG_SUSP = 2;
    localparam int SEC_LOCKDOWN = 1;
    localparam int SEC_FACTORY_LOCK = 0;
    localparam logic FAIL_RST = 1'b0;
    localparam logic LOCKDOWN_RST = 1'b0;

    // ********************************
    // geometry and timing
    // ********************************
    localparam int ADDR_BYTES = 3;
    localparam int PAGE_BYTES = 256;
    localparam int CLK_MHZ = 250;
    localparam int WHOLE_ERASE_TIME_US = 1000;
    localparam int PAGE_PROGRAM_TIME_US = 500;
    localparam int SLEEP_ENTRY_DELAY_NS = 2000;
    localparam int WHOLE_ERASE_CYC = WHOLE_ERASE_TIME_US * CLK_MHZ;
    localparam int PAGE_PROGRAM_CYC = PAGE_PROGRAM_TIME_US * CLK_MHZ;
    localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_DELAY_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [2:0] {
        PH_OPCODE = 3'b000,
        PH_ADDR = 3'b001,
        PH_DATA = 3'b010,
        PH_READ = 3'b011,
        PH_SKIP = 3'b100
    } sfe_phase_t;
endpackage

// File: sfe_sync.sv
`timescale 1ns/1ns
module sfe_sync #(
    parameter int W = 1,
    // reset to the pins' idle levels so no false edge follows reset
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // asynchronous in, synchronised out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta_q <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// File: sfe_sequencer.sv
`timescale 1ns/1ns
// What this block does
// - chip erase needs latch set, erases to ones
// - chip erase only on byte-aligned select rise
// - opcode as 8 single or 2 quad clocks
// - erase timed from select rise, clears busy/latch
// - protect-bit mode: erase only if bits zero
// - individual mode: erase skips protected blocks
// - page program needs latch, 1 to 256 bytes
// - over 256 bytes keeps only last 256
// - low address byte starts, wraps within page
// - opcode, address, data; rise after data byte
// - no program into protected page
// - program timed from rise, clears busy/latch
// - quad program needs quad enable, four lanes
// - sleep command opcode only, delayed entry
// - asleep ignores all but wake command and security register read
// - enter-otp switches access to otp region
// - locked otp refuses every update
// - exit-otp returns to main array
// - security register readable anytime, repeated
// - security write needs latch, sets lockdown
// - security write only on byte-aligned rise
// - security register bit layout
// - protection select chooses protection mode
module sfe_sequencer #(
    parameter int ERASE_CYC = sfe_pkg::WHOLE_ERASE_CYC,
    parameter int PROGRAM_CYC = sfe_pkg::PAGE_PROGRAM_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // flash pins
    input wire logic csN,
    input wire logic sclk,
    input wire logic [3:0] sioIn,
    output logic [3:0] sioOut,
    output logic [3:0] sioOeN,
    // mode and protection
    input wire logic qpiMode,
    input wire logic quadEnable,
    input wire logic protectionModeSelect,
    input wire logic [3:0] blockProtectBits,
    input wire logic nvOtpLockdown,
    input wire logic factoryLock,
    output logic [23:0] tgtAddr,
    input wire logic tgtProtected,
    // array side
    output logic eraseStart,
    output logic eraseSkipProtected,
    output logic progStart,
    output logic [15:0] progPage,
    output logic otpMode,
    input wire logic [7:0] bufIdx,
    output logic [7:0] bufData,
    output logic bufValid,
    // status
    output logic writeInProgress,
    output logic writeEnableLatch,
    output logic deepSleep,
    output logic otpLockdown,
    output logic lockdownWrite
);
    // ********************************
    // pin synchronisers and edges
    // ********************************
    logic csS, sclkS;
    logic [3:0] sioS;
    logic sclkPrev_q, csPrev_q;

    sfe_sync #(.W(6), .RST_VAL(6'h20)) uSync (
        .mclk(mclk),
        .rst(rst),
        .d({csN, sclk, sioIn}),
        .q({csS, sclkS, sioS})
    );

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sclkPrev_q <= 1'b0;
            csPrev_q <= 1'b1;
        end else begin
            sclkPrev_q <= sclkS;
            csPrev_q <= csS;
        end
    end

    logic sclkRise, sclkFall, csRise, csFall;
    assign sclkRise = sclkS & ~sclkPrev_q & ~csS;
    assign sclkFall = ~sclkS & sclkPrev_q & ~csS;
    assign csRise = csS & ~csPrev_q;
    assign csFall = ~csS & csPrev_q;

    // ********************************
    // serial front end
    // ********************************
    sfe_pkg::sfe_phase_t phase_q;
    logic [7:0] sh_q, op_q, wrIdx_q;
    logic [2:0] bitCnt_q;
    logic [1:0] addrCnt_q;
    logic [23:0] addr_q;
    logic extra_q, gotData_q, quad_q;
    logic wide;
    logic [3:0] bitNext;
    logic [7:0] newByte;
    logic byteDone;
    logic wip_q, wel_q, sleepPend_q, sleep_q, otp_q, lock_q;

    // quad program moves address and data four lanes wide
    assign wide = qpiMode | (quad_q & (phase_q != sfe_pkg::PH_OPCODE));
    assign bitNext = {1'b0, bitCnt_q} + (wide ? 4'h4 : 4'h1);
    assign newByte = wide ? {sh_q[3:0], sioS} : {sh_q[6:0], sioS[0]};
    assign byteDone = sclkRise & bitNext[3];

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            phase_q <= sfe_pkg::PH_OPCODE;
            sh_q <= 8'h00;
            op_q <= 8'h00;
            bitCnt_q <= 3'h0;
            addrCnt_q <= 2'h0;
            addr_q <= 24'h000000;
            wrIdx_q <= 8'h00;
            extra_q <= 1'b0;
            gotData_q <= 1'b0;
            quad_q <= 1'b0;
        end else if (csFall) begin
            phase_q <= sfe_pkg::PH_OPCODE;
            bitCnt_q <= 3'h0;
            addrCnt_q <= 2'h0;
            extra_q <= 1'b0;
            gotData_q <= 1'b0;
            quad_q <= 1'b0;
        end else if (sclkRise) begin
            sh_q <= newByte;
            bitCnt_q <= bitNext[2:0];
            if (byteDone) begin
                unique case (phase_q)
                    sfe_pkg::PH_OPCODE: begin
                        op_q <= newByte;
                        if (newByte == sfe_pkg::OP_READ_SECURITY_REG) begin
                            phase_q <= sfe_pkg::PH_READ;
                        end else if (sleep_q | sleepPend_q | wip_q) begin
                            phase_q <= sfe_pkg::PH_SKIP;
                        end else if (newByte == sfe_pkg::OP_PAGE_PROGRAM) begin
                            phase_q <= sfe_pkg::PH_ADDR;
                        end else if (newByte == sfe_pkg::OP_QUAD_PAGE_PROGRAM && quadEnable) begin
                            phase_q <= sfe_pkg::PH_ADDR;
                            quad_q <= 1'b1;
                        end else begin
                            phase_q <= sfe_pkg::PH_SKIP;
                        end
                    end
                    sfe_pkg::PH_ADDR: begin
                        addr_q <= {addr_q[15:0], newByte};
                        addrCnt_q <= addrCnt_q + 2'h1;
                        if (addrCnt_q == 2'(sfe_pkg::ADDR_BYTES - 1)) begin
                            phase_q <= sfe_pkg::PH_DATA;
                            wrIdx_q <= newByte;
                        end
                    end
                    sfe_pkg::PH_DATA: begin
                        gotData_q <= 1'b1;
                        wrIdx_q <= wrIdx_q + 8'h01;
                    end
                    sfe_pkg::PH_READ: begin
                        extra_q <= 1'b1;
                    end
                    sfe_pkg::PH_SKIP: begin
                        extra_q <= 1'b1;
                    end
                    default: begin
                        phase_q <= sfe_pkg::PH_SKIP;
                    end
                endcase
            end
        end
    end

    // ********************************
    // page buffer
    // ********************************
    // the wrapping index overwrites older bytes, so only the last page-full survives
    logic [7:0] pageMem [sfe_pkg::PAGE_BYTES];
    logic [sfe_pkg::PAGE_BYTES-1:0] valid_q;
    logic dataWr;
    assign dataWr = byteDone & (phase_q == sfe_pkg::PH_DATA) & ~csFall;

    always_ff @(posedge mclk) begin
        if (dataWr) begin
            pageMem[wrIdx_q] <= newByte;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            valid_q <= '0;
        end else if (byteDone && phase_q == sfe_pkg::PH_ADDR && addrCnt_q == 2'h0) begin
            valid_q <= '0;
        end else if (dataWr) begin
            valid_q[wrIdx_q] <= 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bufData <= 8'h00;
            bufValid <= 1'b0;
        end else begin
            bufData <= pageMem[bufIdx];
            bufValid <= valid_q[bufIdx];
        end
    end

    // ********************************
    // command execution at select rise
    // ********************************
    logic aligned, onlyOp, isErase, isProg, progBlocked, eraseOk;
    logic [31:0] timer_q;
    logic eFail_q, pFail_q, loaded_q;

    assign aligned = (bitCnt_q == 3'h0) & (phase_q != sfe_pkg::PH_OPCODE);
    assign onlyOp = aligned & ~extra_q & (phase_q == sfe_pkg::PH_SKIP);
    assign isErase = (op_q == sfe_pkg::OP_CHIP_ERASE) | (op_q == sfe_pkg::OP_CHIP_ERASE_ALT);
    assign isProg = aligned & gotData_q & (phase_q == sfe_pkg::PH_DATA);
    // in otp mode only the lockdown matters; otherwise the page lookup decides
    assign progBlocked = otp_q ? lock_q : tgtProtected;
    assign eraseOk = protectionModeSelect | (blockProtectBits == 4'h0);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wel_q <= 1'b0;
            wip_q <= 1'b0;
            sleepPend_q <= 1'b0;
            sleep_q <= 1'b0;
            otp_q <= 1'b0;
            timer_q <= 32'h0;
            eraseStart <= 1'b0;
            progStart <= 1'b0;
            eFail_q <= sfe_pkg::FAIL_RST;
            pFail_q <= sfe_pkg::FAIL_RST;
        end else begin
            eraseStart <= 1'b0;
            progStart <= 1'b0;
            if (timer_q > 32'h1) begin
                timer_q <= timer_q - 32'h1;
            end else if (timer_q == 32'h1) begin
                timer_q <= 32'h0;
                if (sleepPend_q) begin
                    sleepPend_q <= 1'b0;
                    sleep_q <= 1'b1;
                end else begin
                    wip_q <= 1'b0;
                    wel_q <= 1'b0;
                end
            end
            if (csRise) begin
                if (sleep_q | sleepPend_q) begin
                    if (onlyOp && op_q == sfe_pkg::OP_WAKE_FROM_SLEEP) begin
                        sleep_q <= 1'b0;
                        sleepPend_q <= 1'b0;
                        timer_q <= 32'h0;
                    end
                end else if (!wip_q) begin
                    if (onlyOp && op_q == sfe_pkg::OP_WRITE_ENABLE) begin
                        wel_q <= 1'b1;
                    end
                    if (onlyOp && op_q == sfe_pkg::OP_WRITE_DISABLE) begin
                        wel_q <= 1'b0;
                    end
                    if (onlyOp && isErase && wel_q && !otp_q) begin
                        if (eraseOk) begin
                            eraseStart <= 1'b1;
                            wip_q <= 1'b1;
                            timer_q <= 32'(ERASE_CYC);
                            eFail_q <= 1'b0;
                        end else begin
                            eFail_q <= 1'b1;
                        end
                    end
                    if (isProg && wel_q) begin
                        if (!progBlocked) begin
                            progStart <= 1'b1;
                            wip_q <= 1'b1;
                            timer_q <= 32'(PROGRAM_CYC);
                            pFail_q <= 1'b0;
                        end else begin
                            pFail_q <= 1'b1;
                        end
                    end
                    if (onlyOp && op_q == sfe_pkg::OP_DEEP_SLEEP) begin
                        sleepPend_q <= 1'b1;
                        timer_q <= 32'(sfe_pkg::SLEEP_ENTRY_CYC);
                    end
                    if (onlyOp && op_q == sfe_pkg::OP_ENTER_OTP) begin
                        otp_q <= 1'b1;
                    end
                    if (onlyOp && op_q == sfe_pkg::OP_EXIT_OTP) begin
                        otp_q <= 1'b0;
                    end
                    if (onlyOp && op_q == sfe_pkg::OP_WRITE_SECURITY_REG && wel_q) begin
                        wel_q <= 1'b0;
                    end
                end
            end
        end
    end

    // ********************************
    // lockdown flag
    // ********************************
    // the stored bit is caught one edge after reset release, then only ever set
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lock_q <= sfe_pkg::LOCKDOWN_RST;
            loaded_q <= 1'b0;
            lockdownWrite <= 1'b0;
        end else begin
            lockdownWrite <= 1'b0;
            if (!loaded_q) begin
                loaded_q <= 1'b1;
                lock_q <= nvOtpLockdown;
            end else if (csRise && onlyOp && op_q == sfe_pkg::OP_WRITE_SECURITY_REG && wel_q
                         && !wip_q && !sleep_q && !sleepPend_q && !lock_q) begin
                lock_q <= 1'b1;
                lockdownWrite <= 1'b1;
            end
        end
    end

    // ********************************
    // security register readout
    // ********************************
    logic [7:0] secReg, outSh_q;
    logic [2:0] outCnt_q;
    logic [2:0] outNext;

    always_comb begin
        secReg = 8'h00;
        secReg[sfe_pkg::SEC_PROT_SEL] = protectionModeSelect;
        secReg[sfe_pkg::SEC_ERASE_FAIL] = eFail_q;
        secReg[sfe_pkg::SEC_PROG_FAIL] = pFail_q;
        secReg[sfe_pkg::SEC_ERASE_SUSP] = 1'b0;
        secReg[sfe_pkg::SEC_PROG_SUSP] = 1'b0;
        secReg[sfe_pkg::SEC_LOCKDOWN] = lock_q;
        secReg[sfe_pkg::SEC_FACTORY_LOCK] = factoryLock;
    end

    assign outNext = outCnt_q + (qpiMode ? 3'h4 : 3'h1);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            outSh_q <= 8'h00;
            outCnt_q <= 3'h0;
            sioOut <= 4'h0;
            sioOeN <= 4'hF;
        end else if (csS) begin
            sioOeN <= 4'hF;
            outCnt_q <= 3'h0;
        end else if (byteDone && phase_q == sfe_pkg::PH_OPCODE) begin
            outSh_q <= secReg;
            outCnt_q <= 3'h0;
        end else if (sclkFall && phase_q == sfe_pkg::PH_READ) begin
            sioOeN <= qpiMode ? 4'h0 : 4'hD;
            sioOut <= qpiMode ? outSh_q[7:4] : {2'b00, outSh_q[7], 1'b0};
            outCnt_q <= outNext;
            // repeat the value for as long as select stays low
            if (outNext == 3'h0) begin
                outSh_q <= secReg;
            end else begin
                outSh_q <= qpiMode ? {outSh_q[3:0], 4'h0} : {outSh_q[6:0], 1'b0};
            end
        end
    end

    // ********************************
    // outputs
    // ********************************
    assign writeInProgress = wip_q;
    assign writeEnableLatch = wel_q;
    assign deepSleep = sleep_q;
    assign otpMode = otp_q;
    assign otpLockdown = lock_q;
    assign tgtAddr = addr_q;
    assign progPage = addr_q[23:8];
    assign eraseSkipProtected = protectionModeSelect;

    // ********************************
    // checks
    // ********************************
    localparam int slpMax = sfe_pkg::SLEEP_ENTRY_CYC + 2;

    sequence s_busyRun;
        wip_q [*2];
    endsequence

    sequence s_sleepArm;
        $rose(sleepPend_q);
    endsequence

    property p_eraseNeedsLatch;
        @(posedge mclk) disable iff (rst) eraseStart |-> $past(wel_q) && $past(csRise);
    endproperty
    a_eraseNeedsLatch: assert property (p_eraseNeedsLatch) else $error("erase without latch");

    property p_eraseBpZero;
        @(posedge mclk) disable iff (rst)
            eraseStart |-> $past(protectionModeSelect) || $past(blockProtectBits) == 4'h0;
    endproperty
    a_eraseBpZero: assert property (p_eraseBpZero) else $error("erase while protected");

    property p_startBusy;
        @(posedge mclk) disable iff (rst) (eraseStart || progStart) |-> s_busyRun;
    endproperty
    a_startBusy: assert property (p_startBusy) else $error("busy flag not held");

    property p_doneClears;
        @(posedge mclk) disable iff (rst) $fell(wip_q) |-> !wel_q;
    endproperty
    a_doneClears: assert property (p_doneClears) else $error("latch left after cycle");

    property p_progUnprotected;
        @(posedge mclk) disable iff (rst)
            progStart |-> ($past(otp_q) ? !$past(lock_q) : !$past(tgtProtected));
    endproperty
    a_progUnprotected: assert property (p_progUnprotected) else $error("protected program");

    property p_sleepEntry;
        @(posedge mclk) disable iff (rst) s_sleepArm |-> ##[1:slpMax] (sleep_q || !sleepPend_q);
    endproperty
    a_sleepEntry: assert property (p_sleepEntry) else $error("sleep entry late");

    property p_sleepIgnores;
        @(posedge mclk) disable iff (rst) $past(sleep_q) |-> !eraseStart && !progStart && !$rose(wel_q);
    endproperty
    a_sleepIgnores: assert property (p_sleepIgnores) else $error("command taken asleep");

    property p_otpNoErase;
        @(posedge mclk) disable iff (rst) eraseStart |-> !$past(otp_q);
    endproperty
    a_otpNoErase: assert property (p_otpNoErase) else $error("erase in otp mode");

    property p_quadNeedsQe;
        @(posedge mclk) disable iff (rst) (progStart && $past(quad_q)) |-> $past(quadEnable, 2);
    endproperty
    a_quadNeedsQe: assert property (p_quadNeedsQe) else $error("quad program without enable");
endmodule

// File: sfe_host.sv
`timescale 1ns/1ns
// ****
// host controller model
// ****
module sfe_host (
    // clock
    input wire logic mclk,
    // flash pins
    output logic csN,
    output logic sclk,
    output logic [3:0] sioIn,
    input wire logic [3:0] sioOut
);
    logic [7:0] rd;
    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        sioIn = 4'h0;
        rd = 8'h00;
    end
    task automatic waitc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // data moves with the falling link edge, read back late in high phase
    task automatic tick(input logic [3:0] v);
        sclk = 1'b0;
        sioIn = v;
        waitc(4);
        sclk = 1'b1;
        waitc(4);
        rd = {rd[6:0], sioOut[1]};
    endtask
    task automatic frame_on();
        waitc(1);
        csN = 1'b0;
    endtask
    // upper lanes carry garbage in single mode
    task automatic send(input logic [7:0] b, input int n, input logic q);
        if (q) begin
            tick(b[7:4]);
            tick(b[3:0]);
        end else begin
            for (int i = 7; i > 7 - n; i--) begin
                tick({{3{~b[i]}}, b[i]});
            end
        end
    endtask
    // link clock stands still between frames, released lanes flip
    task automatic frame_off();
        waitc(4);
        sclk = 1'b0;
        waitc(4);
        csN = 1'b1;
        sioIn = ~sioIn;
        waitc(8);
    endtask
endmodule

// File: testbench.sv
`timescale 1ns/1ns
module testbench;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic csN, sclk, qpiMode, quadEnable, protectionModeSelect, nvOtpLockdown, factoryLock;
    logic [3:0] sioIn, sioOut, sioOeN, blockProtectBits;
    logic [23:0] tgtAddr;
    logic [15:0] progPage;
    logic [7:0] bufIdx, bufData;
    logic tgtProtected, eraseStart, eraseSkipProtected, progStart, otpMode, bufValid;
    logic writeInProgress, writeEnableLatch, deepSleep, otpLockdown, lockdownWrite;
    int nErase = 0, nProg = 0, nLock = 0, cyc = 0, failures = 0, num_checks = 0;
    sfe_host h (.mclk(mclk), .csN(csN), .sclk(sclk), .sioIn(sioIn), .sioOut(sioOut));
    sfe_sequencer #(.ERASE_CYC(300), .PROGRAM_CYC(10)) uut (.mclk(mclk), .rst(rst),
        .csN(csN), .sclk(sclk), .sioIn(sioIn), .sioOut(sioOut), .sioOeN(sioOeN),
        .qpiMode(qpiMode), .quadEnable(quadEnable),
        .protectionModeSelect(protectionModeSelect), .blockProtectBits(blockProtectBits),
        .nvOtpLockdown(nvOtpLockdown), .factoryLock(factoryLock), .tgtAddr(tgtAddr),
        .tgtProtected(tgtProtected), .eraseStart(eraseStart),
        .eraseSkipProtected(eraseSkipProtected), .progStart(progStart),
        .progPage(progPage), .otpMode(otpMode), .bufIdx(bufIdx), .bufData(bufData),
        .bufValid(bufValid), .writeInProgress(writeInProgress),
        .writeEnableLatch(writeEnableLatch), .deepSleep(deepSleep),
        .otpLockdown(otpLockdown), .lockdownWrite(lockdownWrite));
    always #2 mclk = ~mclk;
    // single-cycle pulses are counted so checks can come later
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        nErase <= nErase + int'(eraseStart === 1'b1);
        nProg <= nProg + int'(progStart === 1'b1);
        nLock <= nLock + int'(lockdownWrite === 1'b1);
        if (cyc == 60000) begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        if (failures == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic frm(input logic [7:0] op, input int tail);
        h.frame_on();
        h.send(op, 8, qpiMode);
        if (tail > 0) h.send(8'h00, tail, 1'b0);
        h.frame_off();
    endtask
    // byte k carries k plus its page-lap count, so overwrites show
    task automatic prog(input logic [7:0] op, input logic [23:0] a, input int nb,
        input int tail, input logic q);
        h.frame_on();
        h.send(op, 8, 1'b0);
        for (int i = 2; i >= 0; i--) h.send(a[i*8 +: 8], 8, q);
        for (int k = 0; k < nb; k++) h.send(8'(k + k / 256), 8, q);
        if (tail > 0) h.send(8'h00, tail, 1'b0);
        h.frame_off();
    endtask
    task automatic rdsec(input logic [7:0] e);
        h.frame_on();
        h.send(sfe_pkg::OP_READ_SECURITY_REG, 8, 1'b0);
        h.send(8'h00, 8, 1'b0);
        chk(h.rd, e);
        chk(sioOeN, 4'hD);
        h.send(8'h00, 8, 1'b0);
        chk(h.rd, e);
        h.frame_off();
        chk(sioOeN, 4'hF);
    endtask
    task automatic bchk(input logic [7:0] i, input logic [7:0] e);
        bufIdx = i;
        h.waitc(2);
        chk(bufData, e);
    endtask
    task automatic idle();
        for (int i = 0; i < 400 && writeInProgress !== 1'b0; i++) h.waitc(1);
        chk(writeInProgress, 1'b0);
    endtask
    initial begin
        {qpiMode, quadEnable, protectionModeSelect, nvOtpLockdown, tgtProtected} = 5'h00;
        factoryLock = 1'b1;
        blockProtectBits = 4'h0;
        bufIdx = 8'h00;
        h.waitc(5);
        rst = 1'b0;
        h.waitc(3);
        frm(sfe_pkg::OP_WRITE_ENABLE, 0);
        chk(writeEnableLatch, 1'b1);
        frm(sfe_pkg::OP_CHIP_ERASE, 0);
        chk(24'(nErase), 24'h1);
        rdsec(8'h01);
        chk(writeInProgress, 1'b1);
        idle();
        chk(writeEnableLatch, 1'b0);
        frm(sfe_pkg::OP_CHIP_ERASE, 0);
        chk(24'(nErase), 24'h1);
        frm(sfe_pkg::OP_WRITE_ENABLE, 0);
        frm(sfe_pkg::OP_CHIP_ERASE, 1);
        chk(24'(nErase), 24'h1);
        blockProtectBits = 4'h2;
        frm(sfe_pkg::OP_CHIP_ERASE, 0);
        chk(24'(nErase), 24'h1);
        rdsec(8'h41);
        protectionModeSelect = 1'b1;
        frm(sfe_pkg::OP_CHIP_ERASE, 0);
        chk(24'(nErase), 24'h2);
        chk(eraseSkipProtected, 1'b1);
        idle();
        {protectionModeSelect, blockProtectBits} = 5'h00;
        frm(sfe_pkg::OP_WRITE_ENABLE, 0);
        prog(sfe_pkg::OP_PAGE_PROGRAM, 24'h1234FE, 3, 0, 1'b0);
        chk(24'(nProg), 24'h1);
        chk(progPage, 16'h1234);
        chk(writeInProgress, 1'b1);
        idle();
        chk(writeEnableLatch, 1'b0);
        bchk(8'hFE, 8'h00);
        bchk(8'hFF, 8'h01);
        bchk(8'h00, 8'h02);
        chk(bufValid, 1'b1);
        bufIdx = 8'h03;
        h.waitc(2);
        chk(bufValid, 1'b0);
        frm(sfe_pkg::OP_WRITE_ENABLE, 0);
        prog(sfe_pkg::OP_PAGE_PROGRAM, 24'h000100, 1, 3, 1'b0);
        chk(24'(nProg), 24'h1);
        tgtProtected = 1'b1;
        prog(sfe_pkg::OP_PAGE_PROGRAM, 24'h000100, 1, 0, 1'b0);
        chk(24'(nProg), 24'h1);
        tgtProtected = 1'b0;
        prog(sfe_pkg::OP_PAGE_PROGRAM, 24'h000200, 257, 0, 1'b0);
        chk(24'(nProg), 24'h2);
        idle();
        bchk(8'h00, 8'h01);
        frm(sfe_pkg::OP_WRITE_ENABLE, 0);
        prog(sfe_pkg::OP_QUAD_PAGE_PROGRAM, 24'h000310, 2, 0, 1'b1);
        chk(24'(nProg), 24'h2);
        quadEnable = 1'b1;
        prog(sfe_pkg::OP_QUAD_PAGE_PROGRAM, 24'h000310, 2, 0, 1'b1);
        chk(24'(nProg), 24'h3);
        chk(tgtAddr, 24'h000310);
        idle();
        bchk(8'h11, 8'h01);
        qpiMode = 1'b1;
        frm(sfe_pkg::OP_WRITE_ENABLE, 0);
        qpiMode = 1'b0;
        chk(writeEnableLatch, 1'b1);
        frm(sfe_pkg::OP_WRITE_SECURITY_REG, 1);
        chk(24'(nLock), 24'h0);
        frm(sfe_pkg::OP_ENTER_OTP, 0);
        chk(otpMode, 1'b1);
        frm(sfe_pkg::OP_WRITE_SECURITY_REG, 0);
        chk(24'(nLock), 24'h1);
        chk(otpLockdown, 1'b1);
        frm(sfe_pkg::OP_WRITE_ENABLE, 0);
        prog(sfe_pkg::OP_PAGE_PROGRAM, 24'h000000, 1, 0, 1'b0);
        chk(24'(nProg), 24'h3);
        frm(sfe_pkg::OP_EXIT_OTP, 0);
        chk(otpMode, 1'b0);
        frm(sfe_pkg::OP_DEEP_SLEEP, 0);
        h.waitc(400);
        chk(deepSleep, 1'b0);
        h.waitc(120);
        chk(deepSleep, 1'b1);
        frm(sfe_pkg::OP_WRITE_DISABLE, 0);
        chk(writeEnableLatch, 1'b1);
        frm(sfe_pkg::OP_WAKE_FROM_SLEEP, 0);
        chk(deepSleep, 1'b0);
        // stored lockdown and factory bits are picked up again on a mid-run reset
        rst = 1'b1;
        {nvOtpLockdown, factoryLock} = 2'b10;
        h.waitc(5);
        rst = 1'b0;
        h.waitc(3);
        chk(otpLockdown, 1'b1);
        rdsec(8'h02);
        frm(sfe_pkg::OP_WRITE_ENABLE, 0);
        frm(sfe_pkg::OP_WRITE_SECURITY_REG, 0);
        chk(24'(nLock), 24'h1);
        tally_and_finish();
    end
endmodule
